/* File: scm_pkg.sv */
// Purpose: Shared constants and types of the sensor command mailbox.
// Assumes: Register offsets are 8-bit pointer values on the serial bus.
// Notes:   Every offset, field position and reset value is named here once.
package scm_pkg;

    localparam logic [7:0] SCM_OFS_INT_CFG    = 8'h03;
    localparam logic [7:0] SCM_OFS_IRQ_ENABLE = 8'h04;
    localparam logic [7:0] SCM_OFS_HOST_PARAM = 8'h17;
    localparam logic [7:0] SCM_OFS_COMMAND    = 8'h18;
    localparam logic [7:0] SCM_OFS_RESPONSE   = 8'h20;
    localparam logic [7:0] SCM_OFS_IRQ_FLAGS  = 8'h21;
    localparam logic [7:0] SCM_OFS_SEQ_PARAM  = 8'h2E;

    localparam logic [7:0] SCM_RST_BYTE       = 8'h00;
    localparam logic [3:0] SCM_RST_COUNT      = 4'h0;

    localparam int SCM_CMD_FLAG_BIT  = 5;
    localparam int SCM_LIGHT_LO_BIT  = 0;
    localparam int SCM_LIGHT_HI_BIT  = 1;
    localparam int SCM_INT_OE_BIT    = 0;
    localparam int SCM_LIGHT_IE_BIT  = 0;
    localparam int SCM_CMD_IE_BIT    = 5;
    localparam int SCM_RESP_ERR_BIT  = 7;

    localparam logic [7:0] SCM_RESP_INVALID = 8'h80;
    localparam logic [7:0] SCM_RESP_OVF_VIS = 8'h8C;
    localparam logic [7:0] SCM_RESP_OVF_IR  = 8'h8D;
    localparam logic [7:0] SCM_RESP_OVF_AUX = 8'h8E;

    typedef enum logic [1:0] {
        SCM_CH_VIS = 2'h0,
        SCM_CH_IR  = 2'h1,
        SCM_CH_AUX = 2'h2
    } scm_chan_t;

    typedef enum logic [4:0] {
        SCM_ST_IDLE = 5'h01,
        SCM_ST_RECV = 5'h02,
        SCM_ST_ACK  = 5'h04,
        SCM_ST_SEND = 5'h08,
        SCM_ST_RACK = 5'h10
    } scm_i2c_state_t;

    // Maps an overflowing channel onto its response code.
    function automatic logic [7:0] scm_ovf_code(input logic [1:0] ch);
        logic [7:0] code;
        code = SCM_RESP_OVF_AUX;
        if (ch == SCM_CH_VIS)
            code = SCM_RESP_OVF_VIS;
        else if (ch == SCM_CH_IR)
            code = SCM_RESP_OVF_IR;
        return code;
    endfunction

endpackage

/* File: scm_sync.sv */
// Purpose: Two-stage synchroniser for asynchronous input levels.
// Assumes: Inputs idle at the level given by RST_VAL.
// Notes:   Only the second stage leaves this module.
`timescale 1ns/1ps
module scm_sync
    import scm_pkg::*;
#(
    parameter int             W       = 2,
    parameter logic [W-1:0]   RST_VAL = '1
)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] stage1;

    if (W < 1)
    begin : g_check
        $error("The synchroniser needs at least one bit.");
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stage1 <= RST_VAL;
            q      <= RST_VAL;
        end
        else
        begin
            stage1 <= d;
            q      <= stage1;
        end
    end

endmodule

/* File: scm_cmd_gate.sv */
// Purpose: Accepts host commands and hands them to the sequencer.
// Assumes: The sequencer takes a command with cmd_ready while cmd_valid is high.
// Notes:   A held error blocks every command except the two that clear it.
`timescale 1ns/1ps
module scm_cmd_gate
    import scm_pkg::*;
#(
    parameter logic [7:0] NOP_CODE   = 8'h00,
    parameter logic [7:0] RESET_CODE = 8'h01
)
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       cmd_write,
    input  wire logic [7:0] cmd_data,
    input  wire logic       error_held,
    input  wire logic       cmd_ready,
    output logic            cmd_valid,
    output logic            wake
);

    if (NOP_CODE == RESET_CODE)
    begin : g_check
        $error("Clearing command codes must differ.");
    end

    wire clearing_cmd = (cmd_data == NOP_CODE) || (cmd_data == RESET_CODE);
    wire accept       = cmd_write && (!error_held || clearing_cmd);
    wire next_valid   = accept || (cmd_valid && !cmd_ready);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cmd_valid <= 1'b0;
            wake      <= 1'b0;
        end
        else
        begin
            cmd_valid <= next_valid;
            wake      <= cmd_write;
        end
    end

endmodule

/* File: scm_mailbox.sv */
// Purpose: Command and response mailbox of a light sensor behind a serial slave port.
// Assumes: scl and sda arrive asynchronously and are sampled by clk at 200 MHz.
// Notes:   Registers are reached by an 8-bit pointer written after the address byte.
// Functional notes
// - Host parameter mailbox, eight bits, resets to zero, feeds the sequencer.
// - Command register is the entry for host work requests to the sequencer.
// - Only a host write to the command register wakes the device.
// - Command errors load the response with a code whose top bit is set.
// - A held error stays until reset, no-op or a host write to the response; other commands are ignored.
// - Errors never stop or alter running autonomous measurements.
// - Responses 0x00 to 0x0F mean success; bits 3:0 are a wrapping counter.
// - Each valid command finished with no error held adds one to the four-bit counter, wrapping.
// - Command completion has no fixed deadline after the write.
// - An unknown command code sets the response to 0x80.
// - Converter overflow codes: 0x8C visible, 0x8D infrared, 0x8E auxiliary.
// - Status holds the command flag at bit 5 and light flags at 1:0.
// - Interrupt asserts when any status bit and its enable are both set.
// - Output enable clear never drives the pin; set drives it low while a status bit and its enable are both set.
// - Sequencer parameter mailbox, eight bits, returns bytes to the host.
`timescale 1ns/1ps
module scm_mailbox
    import scm_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR   = 7'h2A,
    parameter logic [7:0] NOP_CODE   = 8'h00,
    parameter logic [7:0] RESET_CODE = 8'h01
)
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            int_out,
    output logic            int_oe,
    output logic            cmd_valid,
    output logic [7:0]      cmd_code,
    output logic [7:0]      cmd_param,
    input  wire logic       cmd_ready,
    input  wire logic       seq_done,
    input  wire logic       seq_invalid,
    input  wire logic       seq_param_we,
    input  wire logic [7:0] seq_param_data,
    input  wire logic       ovf_event,
    input  wire logic [1:0] ovf_channel,
    input  wire logic       meas_ready,
    input  wire logic [1:0] meas_status,
    output logic            wake
);

    if (DEV_ADDR == 7'h00)
    begin : g_check
        $error("The slave address must not be the general call address.");
    end

    logic [1:0]     sync_q;
    logic           scl_q;
    logic           sda_q;
    scm_i2c_state_t state;
    scm_i2c_state_t next_state;
    logic [3:0]     bit_cnt;
    logic [3:0]     next_cnt;
    logic [7:0]     shreg;
    logic [7:0]     next_sh;
    logic [7:0]     ptr;
    logic [7:0]     next_ptr;
    logic           addr_phase;
    logic           next_addr_phase;
    logic           ptr_phase;
    logic           next_ptr_phase;
    logic           rnw;
    logic           next_rnw;
    logic           bus_wr;
    logic [7:0]     host_param_mailbox;
    logic [7:0]     command_mailbox;
    logic [7:0]     response_mailbox;
    logic [7:0]     sequencer_param_mailbox;
    logic           cmd_flag;
    logic [1:0]     light_measure_flag;
    logic           int_oe_cfg;
    logic           cmd_ie;
    logic           light_ie;

    scm_sync #(
        .W       (2),
        .RST_VAL (2'h3)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({scl_in, sda_in}),
        .q   (sync_q)
    );

    wire scl_s      = sync_q[1];
    wire sda_s      = sync_q[0];
    wire scl_rise   = scl_s && !scl_q;
    wire scl_fall   = !scl_s && scl_q;
    wire start_cond = scl_s && scl_q && sda_q && !sda_s;
    wire stop_cond  = scl_s && scl_q && !sda_q && sda_s;
    wire addr_match = (shreg[7:1] == DEV_ADDR);

    // Read data for the byte addressed by the pointer.
    function automatic logic [7:0] read_mux(input logic [7:0] a);
        logic [7:0] v;
        v = SCM_RST_BYTE;
        unique case (a)
            SCM_OFS_INT_CFG:    v[SCM_INT_OE_BIT] = int_oe_cfg;
            SCM_OFS_IRQ_ENABLE:
            begin
                v[SCM_LIGHT_IE_BIT] = light_ie;
                v[SCM_CMD_IE_BIT]   = cmd_ie;
            end
            SCM_OFS_HOST_PARAM: v = host_param_mailbox;
            SCM_OFS_COMMAND:    v = command_mailbox;
            SCM_OFS_RESPONSE:   v = response_mailbox;
            SCM_OFS_IRQ_FLAGS:
            begin
                v[SCM_CMD_FLAG_BIT] = cmd_flag;
                v[SCM_LIGHT_HI_BIT] = light_measure_flag[1];
                v[SCM_LIGHT_LO_BIT] = light_measure_flag[0];
            end
            SCM_OFS_SEQ_PARAM:  v = sequencer_param_mailbox;
            default:            v = SCM_RST_BYTE;
        endcase
        return v;
    endfunction

    // A procedural block, so that flag and register changes reach the read data as well.
    logic [7:0] rd_data;
    always_comb
    begin
        rd_data = read_mux(ptr);
    end

    // Serial slave protocol engine.
    always_comb
    begin
        next_state      = state;
        next_cnt        = bit_cnt;
        next_sh         = shreg;
        next_ptr        = ptr;
        next_addr_phase = addr_phase;
        next_ptr_phase  = ptr_phase;
        next_rnw        = rnw;
        bus_wr          = 1'b0;
        if (start_cond)
        begin
            next_state      = SCM_ST_RECV;
            next_cnt        = 4'h0;
            next_addr_phase = 1'b1;
        end
        else if (stop_cond)
        begin
            next_state = SCM_ST_IDLE;
        end
        else
        begin
            unique case (state)
                SCM_ST_IDLE:
                begin
                    next_state = SCM_ST_IDLE;
                end
                SCM_ST_RECV:
                begin
                    if (scl_rise)
                    begin
                        next_sh  = {shreg[6:0], sda_s};
                        next_cnt = 4'(bit_cnt + 4'h1);
                    end
                    else if (scl_fall && bit_cnt == 4'h8)
                    begin
                        if (addr_phase)
                        begin
                            next_addr_phase = 1'b0;
                            next_rnw        = shreg[0];
                            next_ptr_phase  = !shreg[0];
                            next_state      = addr_match ? SCM_ST_ACK : SCM_ST_IDLE;
                        end
                        else if (ptr_phase)
                        begin
                            next_ptr       = shreg;
                            next_ptr_phase = 1'b0;
                            next_state     = SCM_ST_ACK;
                        end
                        else
                        begin
                            bus_wr     = 1'b1;
                            next_ptr   = 8'(ptr + 8'h01);
                            next_state = SCM_ST_ACK;
                        end
                    end
                end
                SCM_ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_cnt = 4'h0;
                        if (rnw)
                        begin
                            next_state = SCM_ST_SEND;
                            next_sh    = rd_data;
                            next_ptr   = 8'(ptr + 8'h01);
                        end
                        else
                        begin
                            next_state = SCM_ST_RECV;
                        end
                    end
                end
                SCM_ST_SEND:
                begin
                    if (scl_fall)
                    begin
                        next_sh  = {shreg[6:0], 1'b0};
                        next_cnt = 4'(bit_cnt + 4'h1);
                        if (bit_cnt == 4'h7)
                            next_state = SCM_ST_RACK;
                    end
                end
                SCM_ST_RACK:
                begin
                    if (scl_rise && sda_s)
                    begin
                        next_state = SCM_ST_IDLE;
                    end
                    else if (scl_fall)
                    begin
                        next_state = SCM_ST_SEND;
                        next_cnt   = 4'h0;
                        next_sh    = rd_data;
                        next_ptr   = 8'(ptr + 8'h01);
                    end
                end
                default:
                begin
                    next_state = SCM_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
            state      <= SCM_ST_IDLE;
            bit_cnt    <= 4'h0;
            shreg      <= SCM_RST_BYTE;
            ptr        <= SCM_RST_BYTE;
            addr_phase <= 1'b0;
            ptr_phase  <= 1'b0;
            rnw        <= 1'b0;
        end
        else
        begin
            scl_q      <= scl_s;
            sda_q      <= sda_s;
            state      <= next_state;
            bit_cnt    <= next_cnt;
            shreg      <= next_sh;
            ptr        <= next_ptr;
            addr_phase <= next_addr_phase;
            ptr_phase  <= next_ptr_phase;
            rnw        <= next_rnw;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = (state == SCM_ST_ACK) || ((state == SCM_ST_SEND) && !shreg[7]);

    // Register write decode.
    wire wr_int_cfg    = bus_wr && (ptr == SCM_OFS_INT_CFG);
    wire wr_irq_enable = bus_wr && (ptr == SCM_OFS_IRQ_ENABLE);
    wire wr_host_param = bus_wr && (ptr == SCM_OFS_HOST_PARAM);
    wire wr_command    = bus_wr && (ptr == SCM_OFS_COMMAND);
    wire wr_response   = bus_wr && (ptr == SCM_OFS_RESPONSE);
    wire wr_irq_flags  = bus_wr && (ptr == SCM_OFS_IRQ_FLAGS);
    wire wr_seq_param  = bus_wr && (ptr == SCM_OFS_SEQ_PARAM);

    wire error_held = response_mailbox[SCM_RESP_ERR_BIT];

    scm_cmd_gate #(
        .NOP_CODE   (NOP_CODE),
        .RESET_CODE (RESET_CODE)
    ) u_cmd_gate (
        .clk        (clk),
        .rst        (rst),
        .cmd_write  (wr_command),
        .cmd_data   (shreg),
        .error_held (error_held),
        .cmd_ready  (cmd_ready),
        .cmd_valid  (cmd_valid),
        .wake       (wake)
    );

    assign cmd_code  = command_mailbox;
    assign cmd_param = host_param_mailbox;

    // Response update: overflow, then command result, then host write.
    wire [7:0] resp_count = {4'h0, 4'(response_mailbox[3:0] + 4'h1)};
    wire [7:0] resp_done  = seq_invalid ? SCM_RESP_INVALID
                          : (error_held ? SCM_RST_BYTE : resp_count);
    wire [7:0] next_response = ovf_event ? scm_ovf_code(ovf_channel)
                             : seq_done  ? resp_done
                             : wr_response ? shreg
                             : response_mailbox;

    // Hardware setting of a flag wins over a host clear in the same cycle.
    wire       next_cmd_flag = seq_done
                             || (cmd_flag && !(wr_irq_flags && shreg[SCM_CMD_FLAG_BIT]));
    wire [1:0] light_clear   = wr_irq_flags ? shreg[1:0] : 2'h0;
    wire [1:0] light_set     = meas_ready ? meas_status : 2'h0;
    wire [1:0] next_light    = light_set | (light_measure_flag & ~light_clear);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            host_param_mailbox      <= SCM_RST_BYTE;
            command_mailbox         <= SCM_RST_BYTE;
            response_mailbox        <= SCM_RST_BYTE;
            sequencer_param_mailbox <= SCM_RST_BYTE;
            cmd_flag                <= 1'b0;
            light_measure_flag      <= 2'h0;
            int_oe_cfg              <= 1'b0;
            cmd_ie                  <= 1'b0;
            light_ie                <= 1'b0;
        end
        else
        begin
            if (wr_host_param)
                host_param_mailbox <= shreg;
            if (wr_command)
                command_mailbox <= shreg;
            if (seq_param_we)
                sequencer_param_mailbox <= seq_param_data;
            else if (wr_seq_param)
                sequencer_param_mailbox <= shreg;
            if (wr_int_cfg)
                int_oe_cfg <= shreg[SCM_INT_OE_BIT];
            if (wr_irq_enable)
            begin
                cmd_ie   <= shreg[SCM_CMD_IE_BIT];
                light_ie <= shreg[SCM_LIGHT_IE_BIT];
            end
            response_mailbox   <= next_response;
            cmd_flag           <= next_cmd_flag;
            light_measure_flag <= next_light;
        end
    end

    wire int_match = (cmd_flag && cmd_ie) || ((|light_measure_flag) && light_ie);

    assign int_out = 1'b0;
    assign int_oe  = int_oe_cfg && int_match;

endmodule

/* File: scm_mailbox_assertions.sv */
// Purpose: Port checks of the sensor command mailbox.
// Assumes: Bound into every scm_mailbox instance.
// Notes:   One clock domain with synchronous reset.
`timescale 1ns/1ps
module scm_mailbox_assertions
    import scm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       scl_in,
    input  wire logic       sda_oe,
    input  wire logic       int_out,
    input  wire logic       int_oe,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_code,
    input  wire logic       cmd_ready,
    input  wire logic       wake
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_take;
        cmd_valid && cmd_ready;
    endsequence
    sequence s_wake_gap;
        wake ##1 !wake [*8];
    endsequence
    AST_RESET_QUIET: assert property ($fell(rst) |->
        !cmd_valid && !wake && !sda_oe && !int_oe) else $error("active after reset");
    AST_INT_NEVER_HIGH: assert property (int_out == 1'b0)
        else $error("int driven high");
    AST_WAKE_GAP: assert property (wake |-> s_wake_gap)
        else $error("wake not a single pulse");
    AST_CODE_WAKES: assert property ($changed(cmd_code) |-> wake)
        else $error("command write without wake");
    AST_VALID_CAUSE: assert property ($rose(cmd_valid) |-> wake)
        else $error("command raised without write");
    AST_VALID_WAIT: assert property (cmd_valid && !cmd_ready |=> cmd_valid)
        else $error("command dropped before taken");
    AST_TAKE_DROP: assert property (s_take |=> !cmd_valid || wake)
        else $error("command kept after taken");
    AST_SDA_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data changed while clock high");
endmodule
bind scm_mailbox scm_mailbox_assertions i_scm_mailbox_assertions (
    .clk(clk), .rst(rst), .scl_in(scl_in), .sda_oe(sda_oe), .int_out(int_out),
    .int_oe(int_oe), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready),
    .wake(wake)
);

/* File: scm_host_model.sv */
// Purpose: Host controller model driving the serial register bus.
// Assumes: SDA has a pull-up; the device pulls it low through sda_oe.
// Notes:   SCL stays high between frames; one bit takes 16 clocks.
`timescale 1ns/1ps
module scm_host_model
#(
    parameter logic [6:0] ADDR = 7'h2A
)
(
    input  wire logic clk,
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda
);
    logic       sda_m = 1'b1;
    logic [7:0] sh;
    assign sda = sda_m & !sda_oe;
    initial scl = 1'b1;
    task automatic step(input logic c, input logic d);
        scl <= c;
        sda_m <= d;
        repeat (4) @(posedge clk);
    endtask
    task automatic put_bit(input logic b);
        step(1'b0, b);
        step(1'b1, b);
        sh = {sh[6:0], sda};
        step(1'b1, b);
        step(1'b0, b);
    endtask
    // Start when s is high, stop when s is low.
    task automatic cond(input logic s);
        step(1'b0, s);
        step(1'b1, s);
        step(1'b1, !s);
        step(!s, !s);
    endtask
    task automatic put_byte(input logic [7:0] d, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--)
            put_bit(d[i]);
        q = sh;
        put_bit(1'b1);
        ack = !sh[0];
    endtask
    task automatic xfer(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d,
                        input logic rd, output logic [7:0] q, output logic ok);
        logic k1, k2, k3;
        cond(1'b1);
        put_byte(a, q, k1);
        put_byte(p, q, k2);
        if (rd)
        begin
            cond(1'b1);
            put_byte({ADDR, 1'b1}, q, k3);
            put_byte(8'hFF, q, ok);
        end
        else
            put_byte(d, q, k3);
        cond(1'b0);
        ok = k1 & k2 & k3;
    endtask
endmodule

/* File: scm_mailbox_tb_top.sv */
// Purpose: Self-checking bench of the sensor command mailbox.
// Assumes: The host model owns the bus; a small sequencer answers commands.
// Notes:   Register cases come from a table; command, error and reset cases follow.
`timescale 1ns/1ps
module scm_mailbox_tb_top
    import scm_pkg::*;
;
    typedef struct packed { logic [7:0] ofs; logic [7:0] wr; logic [7:0] rd; } scm_row_t;
    logic       clk, rst, scl, sda, sda_out, sda_oe, int_out, int_oe, wake, ok, bad;
    logic       cmd_valid, cmd_ready, seq_done, seq_invalid, seq_param_we, ovf_event;
    logic       meas_ready;
    logic [7:0] cmd_code, cmd_param, seq_param_data, q;
    logic [1:0] ovf_channel, meas_status;
    int         num_errors, n_tests, n_wake, n_taken, cyc, dly;
    scm_row_t   rows [7] = '{
        '{SCM_OFS_HOST_PARAM, 8'hA5, 8'hA5},
        '{SCM_OFS_SEQ_PARAM, 8'h3C, 8'h3C},
        '{SCM_OFS_RESPONSE, 8'h05, 8'h05},
        '{SCM_OFS_IRQ_FLAGS, 8'hFF, 8'h00},
        '{8'h50, 8'h77, 8'h00},
        '{SCM_OFS_INT_CFG, 8'h01, 8'h01},
        '{SCM_OFS_IRQ_ENABLE, 8'h21, 8'h21}
    };
    scm_mailbox i_scm_mailbox (
        .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .int_out(int_out), .int_oe(int_oe), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_param(cmd_param), .cmd_ready(cmd_ready), .seq_done(seq_done),
        .seq_invalid(seq_invalid), .seq_param_we(seq_param_we),
        .seq_param_data(seq_param_data), .ovf_event(ovf_event), .ovf_channel(ovf_channel),
        .meas_ready(meas_ready), .meas_status(meas_status), .wake(wake)
    );
    scm_host_model i_scm_host_model (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic complete_run();
        if (num_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Sequencer stand-in: takes a command, finishes it 30 clocks later.
    always @(posedge clk)
    begin
        cyc++;
        seq_done <= 1'b0;
        if (wake === 1'b1)
            n_wake++;
        if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
        begin
            n_taken++;
            cmd_ready <= 1'b0;
            bad <= (cmd_code === 8'hFF);
            dly <= 30;
        end
        else if (dly > 0)
        begin
            dly <= dly - 1;
            if (dly == 1)
            begin
                seq_done <= 1'b1;
                seq_invalid <= bad;
                cmd_ready <= 1'b1;
            end
        end
        if (cyc == 60000)
        begin
            num_errors++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic [7:0] p, input logic [7:0] d, input logic rd);
        i_scm_host_model.xfer(8'h54, p, d, rd, q, ok);
        check("ack", {7'h00, ok}, 8'h01);
    endtask
    task automatic rchk(input logic [7:0] p, input logic [7:0] exp);
        bus(p, 8'h00, 1'b1);
        check("register", q, exp);
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] old, input logic [7:0] exp);
        bus(SCM_OFS_COMMAND, c, 1'b0);
        q = old;
        for (int i = 0; i < 8 && q === old; i++)
            bus(SCM_OFS_RESPONSE, 8'h00, 1'b1);
        check("response", q, exp);
    endtask
    initial
    begin
        rst = 1'b1;
        cmd_ready = 1'b1;
        bad = 1'b0;
        seq_done = 1'b0;
        seq_invalid = 1'b0;
        seq_param_we = 1'b0;
        seq_param_data = 8'h00;
        ovf_event = 1'b0;
        ovf_channel = 2'h0;
        meas_ready = 1'b0;
        meas_status = 2'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        foreach (rows[i])
        begin
            bus(rows[i].ofs, rows[i].wr, 1'b0);
            rchk(rows[i].ofs, rows[i].rd);
        end
        check("wake", 8'(n_wake), 8'h00);
        seq_param_data <= 8'h5A;
        seq_param_we <= 1'b1;
        @(posedge clk);
        seq_param_we <= 1'b0;
        rchk(SCM_OFS_SEQ_PARAM, 8'h5A);
        cmd(8'h05, 8'h05, 8'h06);
        check("code", cmd_code, 8'h05);
        check("param", cmd_param, 8'hA5);
        rchk(SCM_OFS_IRQ_FLAGS, 8'h20);
        check("int", {7'h00, int_oe}, 8'h01);
        bus(SCM_OFS_INT_CFG, 8'h00, 1'b0);
        check("int", {7'h00, int_oe}, 8'h00);
        bus(SCM_OFS_INT_CFG, 8'h01, 1'b0);
        bus(SCM_OFS_IRQ_FLAGS, 8'h20, 1'b0);
        check("int", {7'h00, int_oe}, 8'h00);
        bus(SCM_OFS_RESPONSE, 8'h0F, 1'b0);
        cmd(8'h07, 8'h0F, 8'h00);
        cmd(8'hFF, 8'h00, SCM_RESP_INVALID);
        bus(SCM_OFS_COMMAND, 8'h05, 1'b0);
        rchk(SCM_OFS_RESPONSE, SCM_RESP_INVALID);
        check("taken", 8'(n_taken), 8'h03);
        check("wake", 8'(n_wake), 8'h04);
        meas_status <= 2'h2;
        meas_ready <= 1'b1;
        @(posedge clk);
        meas_ready <= 1'b0;
        rchk(SCM_OFS_IRQ_FLAGS, 8'h22);
        check("int", {7'h00, int_oe}, 8'h01);
        bus(SCM_OFS_IRQ_FLAGS, 8'h20, 1'b0);
        check("int", {7'h00, int_oe}, 8'h01);
        for (int i = 0; i < 3; i++)
        begin
            ovf_channel <= i[1:0];
            ovf_event <= 1'b1;
            @(posedge clk);
            ovf_event <= 1'b0;
            rchk(SCM_OFS_RESPONSE, SCM_RESP_OVF_VIS + 8'(i));
            cmd(8'(i % 2), SCM_RESP_OVF_VIS + 8'(i), 8'h00);
        end
        i_scm_host_model.xfer(8'hAA, SCM_OFS_HOST_PARAM, 8'h11, 1'b0, q, ok);
        check("nak", {7'h00, ok}, 8'h00);
        rchk(SCM_OFS_HOST_PARAM, 8'hA5);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        foreach (rows[i])
            rchk(rows[i].ofs, 8'h00);
        check("code", cmd_code, 8'h00);
        complete_run();
    end
endmodule
